// ===== verilog/nscap_cfg.svh
// offsets, field positions, reset values and timing counts of the namespace capability bank
`ifndef NSCAP_CFG_SVH
`define NSCAP_CFG_SVH

`define NSCAP_CLK_MHZ        40
`define NSCAP_FMT_STEP_NS    1000
`define NSCAP_FMT_STEP_CYC   ((`NSCAP_FMT_STEP_NS * `NSCAP_CLK_MHZ + 999) / 1000)

`define NSCAP_OFF_FMT_SEL    8'h1A
`define NSCAP_OFF_PROT       8'h1D
`define NSCAP_OFF_SHARE      8'h1E
`define NSCAP_OFF_RESV       8'h1F
`define NSCAP_OFF_PROG       8'h20
`define NSCAP_OFF_CFG        8'h40
`define NSCAP_OFF_RTYPE      8'h41
`define NSCAP_OFF_VER_MAJ    8'h42
`define NSCAP_OFF_VER_MIN    8'h43
`define NSCAP_OFF_FMT_CMD    8'h44
`define NSCAP_OFF_STATUS     8'h45

`define NSCAP_CFG_SHARED_BIT 0
`define NSCAP_CFG_PROG_BIT   1
`define NSCAP_CFG_PTPL_BIT   2
`define NSCAP_CFG_KEYNEW_BIT 3
`define NSCAP_RESV_KEY_BIT   7
`define NSCAP_PROG_SUP_BIT   7
`define NSCAP_CMD_PROT_LSB   4

`define NSCAP_CFG_RST        4'h0
`define NSCAP_RTYPE_RST      6'h00
`define NSCAP_VER_MAJ_RST    8'h01
`define NSCAP_VER_MIN_RST    8'h04
`define NSCAP_FMT_SEL_RST    4'h0
`define NSCAP_PROT_RST       3'h0
`define NSCAP_PROT_MAX       3'h3
`define NSCAP_FMT_FULL_PCT   7'h64
`define NSCAP_VER_KEY_MAJ    8'h01
`define NSCAP_VER_KEY_MIN    8'h03

`endif

// ===== verilog/nscap_pkg.sv
// types and shared decoding of the namespace capability bank
`include "nscap_cfg.svh"
package nscap_pkg;
  typedef logic [7:0] nscap_byte_t;
  typedef enum logic {NSCAP_FMT_IDLE, NSCAP_FMT_RUN} nscap_fmt_state_t;

  function automatic logic nscap_ver_ge13(input nscap_byte_t maj, input nscap_byte_t min);
    nscap_ver_ge13 = (maj > `NSCAP_VER_KEY_MAJ) || ((maj == `NSCAP_VER_KEY_MAJ) && (min >= `NSCAP_VER_KEY_MIN));
  endfunction
endpackage

// ===== verilog/nscap_fmt_if.sv
// link between register front end and format engine
`timescale 1ns/1ps
interface nscap_fmt_if;
  logic       start;
  logic [3:0] tgt_fmt;
  logic [2:0] tgt_prot;
  logic       busy;
  logic [6:0] remaining;
  logic [3:0] cur_fmt;
  logic [2:0] cur_prot;

  modport engine (input start, tgt_fmt, tgt_prot, output busy, remaining, cur_fmt, cur_prot);
  modport front  (output start, tgt_fmt, tgt_prot, input busy, remaining, cur_fmt, cur_prot);
endinterface

// ===== verilog/nscap_fmt_engine.sv
// format engine: remaining percentage and committed format
`timescale 1ns/1ps
`include "nscap_cfg.svh"
module nscap_fmt_engine
  import nscap_pkg::*;
#(
  parameter int STEP_CYCLES = `NSCAP_FMT_STEP_CYC
) (
  input  wire logic   mclk_in,
  input  wire logic   rst_in,
  nscap_fmt_if.engine fmt
);
  localparam int CW = $clog2(STEP_CYCLES + 1);

  nscap_fmt_state_t state_reg;
  logic [CW-1:0]    step_reg;
  logic [6:0]       pct_reg;
  logic [3:0]       tfmt_reg;
  logic [2:0]       tprot_reg;
  logic [3:0]       fmt_reg;
  logic [2:0]       prot_reg;
  logic             step_done;
  logic             last_step;

  assign step_done = (state_reg == NSCAP_FMT_RUN) && (step_reg == CW'(STEP_CYCLES - 1));
  assign last_step = step_done && (pct_reg == 7'h01);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= NSCAP_FMT_IDLE;
    end else begin
      case (state_reg)
        NSCAP_FMT_IDLE: if (fmt.start) state_reg <= NSCAP_FMT_RUN;
        NSCAP_FMT_RUN:  if (last_step) state_reg <= NSCAP_FMT_IDLE;
        default:        state_reg <= NSCAP_FMT_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      step_reg <= '0;
    end else if ((state_reg != NSCAP_FMT_RUN) || step_done) begin
      step_reg <= '0;
    end else begin
      step_reg <= step_reg + CW'(1);
    end
  end

  // remaining share only counts down while running
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pct_reg <= 7'h00;
    end else if ((state_reg == NSCAP_FMT_IDLE) && fmt.start) begin
      pct_reg <= `NSCAP_FMT_FULL_PCT;
    end else if (step_done) begin
      pct_reg <= pct_reg - 7'h01;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tfmt_reg  <= `NSCAP_FMT_SEL_RST;
      tprot_reg <= `NSCAP_PROT_RST;
    end else if ((state_reg == NSCAP_FMT_IDLE) && fmt.start) begin
      tfmt_reg  <= fmt.tgt_fmt;
      tprot_reg <= fmt.tgt_prot;
    end
  end

  // new format takes effect on the edge the share reaches zero
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fmt_reg  <= `NSCAP_FMT_SEL_RST;
      prot_reg <= `NSCAP_PROT_RST;
    end else if (last_step) begin
      fmt_reg  <= tfmt_reg;
      prot_reg <= tprot_reg;
    end
  end

  assign fmt.busy      = (state_reg == NSCAP_FMT_RUN);
  assign fmt.remaining = pct_reg;
  assign fmt.cur_fmt   = fmt_reg;
  assign fmt.cur_prot  = prot_reg;
endmodule // nscap_fmt_engine

// ===== verilog/nscap_resv_enc.sv
// reservation capability byte encoder
`timescale 1ns/1ps
`include "nscap_cfg.svh"
module nscap_resv_enc
  import nscap_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic [5:0]  types_in,
  input  wire logic        ptpl_in,
  input  wire logic        key_new_in,
  input  wire nscap_byte_t ver_maj_in,
  input  wire nscap_byte_t ver_min_in,
  output nscap_byte_t      resv_out
);
  nscap_byte_t resv_reg;

  // no types means no reservations at all
  // key semantics forced new from the version
  // type and persistence bits only when supported
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      resv_reg <= 8'h00;
    end else if (types_in == 6'h00) begin
      resv_reg <= 8'h00;
    end else begin
      resv_reg <= {key_new_in | nscap_ver_ge13(ver_maj_in, ver_min_in), types_in, ptpl_in};
    end
  end

  assign resv_out = resv_reg;
endmodule // nscap_resv_enc

// ===== verilog/nscap_top.sv
// namespace capability register bank with format progress
//
// Functional notes
// - protection code 0..3 only, 4..7 never shown
// - sharing bit0 set when shared, rest zero
// - sharing bit0 clear for private namespace
// - reservation byte zero when no reservations
// - reservation bit7 selects key override semantics
// - bit7 forced one when version is 1.3+
// - bits 6..3 follow the four registrant types
// - bits 2..1 follow exclusive and write-exclusive types
// - bit0 set only with power-loss persistence
// - progress bit7 when supported, else byte zero
// - bits 6..0 give remaining format percentage
// - zero only when idle and format committed
// - format select low nibble names format in use
`timescale 1ns/1ps
`include "nscap_cfg.svh"
module nscap_top
  import nscap_pkg::*;
#(
  parameter int STEP_CYCLES = `NSCAP_FMT_STEP_CYC
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire nscap_byte_t addr_in,
  input  wire nscap_byte_t wr_data_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output nscap_byte_t      rd_data_out,
  output logic             fmt_busy_out
);
  nscap_fmt_if fmt ();

  logic [3:0]  cfg_reg;
  logic [5:0]  rtype_reg;
  nscap_byte_t ver_maj_reg;
  nscap_byte_t ver_min_reg;
  logic        reject_reg;
  nscap_byte_t rd_data_reg;
  logic        busy_reg;
  nscap_byte_t resv_byte;
  nscap_byte_t rd_next;
  logic        cmd_wr;
  logic        cmd_ok;

  function automatic logic hit(input nscap_byte_t a, input nscap_byte_t off);
    hit = (a == off);
  endfunction

  nscap_fmt_engine #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_engine (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .fmt     (fmt)
  );

  nscap_resv_enc u_resv (
    .mclk_in    (mclk_in),
    .rst_in     (rst_in),
    .types_in   (rtype_reg),
    .ptpl_in    (cfg_reg[`NSCAP_CFG_PTPL_BIT]),
    .key_new_in (cfg_reg[`NSCAP_CFG_KEYNEW_BIT]),
    .ver_maj_in (ver_maj_reg),
    .ver_min_in (ver_min_reg),
    .resv_out   (resv_byte)
  );

  // configuration writes
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_reg     <= `NSCAP_CFG_RST;
      rtype_reg   <= `NSCAP_RTYPE_RST;
      ver_maj_reg <= `NSCAP_VER_MAJ_RST;
      ver_min_reg <= `NSCAP_VER_MIN_RST;
    end else if (wr_in) begin
      if (hit(addr_in, `NSCAP_OFF_CFG)) cfg_reg <= wr_data_in[3:0];
      if (hit(addr_in, `NSCAP_OFF_RTYPE)) rtype_reg <= wr_data_in[6:1];
      if (hit(addr_in, `NSCAP_OFF_VER_MAJ)) ver_maj_reg <= wr_data_in;
      if (hit(addr_in, `NSCAP_OFF_VER_MIN)) ver_min_reg <= wr_data_in;
    end
  end

  // format command, reserved protection codes refused
  assign cmd_wr = wr_in && hit(addr_in, `NSCAP_OFF_FMT_CMD);
  assign cmd_ok = cmd_wr && !fmt.busy &&
                  (wr_data_in[`NSCAP_CMD_PROT_LSB +: 3] <= `NSCAP_PROT_MAX);

  assign fmt.start    = cmd_ok;
  assign fmt.tgt_fmt  = wr_data_in[3:0];
  assign fmt.tgt_prot = wr_data_in[`NSCAP_CMD_PROT_LSB +: 3];

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      reject_reg <= 1'b0;
    end else if (cmd_wr) begin
      reject_reg <= !cmd_ok;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= fmt.busy;
    end
  end

  // read multiplexer
  always_comb begin
    rd_next = 8'h00;
    case (addr_in)
      `NSCAP_OFF_FMT_SEL: rd_next = {4'h0, fmt.cur_fmt};
      `NSCAP_OFF_PROT:    rd_next = {5'h00, fmt.cur_prot};
      `NSCAP_OFF_SHARE:   rd_next = {7'h00, cfg_reg[`NSCAP_CFG_SHARED_BIT]};
      `NSCAP_OFF_RESV:    rd_next = resv_byte;
      `NSCAP_OFF_PROG: begin
        if (cfg_reg[`NSCAP_CFG_PROG_BIT]) begin
          rd_next = {1'b1, fmt.remaining};
        end else begin
          rd_next = 8'h00;
        end
      end
      `NSCAP_OFF_CFG:     rd_next = {4'h0, cfg_reg};
      `NSCAP_OFF_RTYPE:   rd_next = {1'b0, rtype_reg, 1'b0};
      `NSCAP_OFF_VER_MAJ: rd_next = ver_maj_reg;
      `NSCAP_OFF_VER_MIN: rd_next = ver_min_reg;
      `NSCAP_OFF_STATUS:  rd_next = {6'h00, reject_reg, fmt.busy};
      default:            rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_reg <= 8'h00;
    end else if (rd_in) begin
      rd_data_reg <= rd_next;
    end else begin
      rd_data_reg <= 8'h00;
    end
  end

  assign rd_data_out  = rd_data_reg;
  assign fmt_busy_out = busy_reg;

  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  logic ver13_h;
  assign ver13_h = nscap_ver_ge13(ver_maj_reg, ver_min_reg);

  logic [3:0] chk_fmt_reg;
  logic [2:0] chk_prot_reg;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      chk_fmt_reg  <= `NSCAP_FMT_SEL_RST;
      chk_prot_reg <= `NSCAP_PROT_RST;
    end else if (cmd_wr && !fmt.busy && (wr_data_in[`NSCAP_CMD_PROT_LSB +: 3] <= `NSCAP_PROT_MAX)) begin
      chk_fmt_reg  <= wr_data_in[3:0];
      chk_prot_reg <= wr_data_in[`NSCAP_CMD_PROT_LSB +: 3];
    end
  end

  sequence s_rd_at(nscap_byte_t off);
    rd_in && (addr_in == off);
  endsequence

  sequence s_resv_live;
    s_rd_at(`NSCAP_OFF_RESV) ##0 ($past(rtype_reg) != 6'h00);
  endsequence

  sequence s_fmt_start;
    fmt.start && !fmt.busy;
  endsequence

  sequence s_fmt_last;
    fmt.busy && (fmt.remaining == 7'h01);
  endsequence

  a_prot_code_legal: assert property (
    s_rd_at(`NSCAP_OFF_PROT) |=> (rd_data_out[7:3] == 5'h00) && (rd_data_out[2:0] <= `NSCAP_PROT_MAX))
    else $error("protection code out of range");

  a_prot_cmd_refused: assert property (
    (cmd_wr && !fmt.busy && (wr_data_in[`NSCAP_CMD_PROT_LSB +: 3] > `NSCAP_PROT_MAX)) ##1 !cmd_wr
      |-> (reject_reg && !fmt.busy) [*2])
    else $error("reserved protection code accepted");

  a_share_reserved: assert property (
    s_rd_at(`NSCAP_OFF_SHARE) |=> rd_data_out[7:1] == 7'h00)
    else $error("sharing reserved bits not zero");

  a_share_private: assert property (
    s_rd_at(`NSCAP_OFF_SHARE) |=> rd_data_out[0] == $past(cfg_reg[`NSCAP_CFG_SHARED_BIT]))
    else $error("sharing bit does not follow setting");

  a_resv_none_zero: assert property (
    (s_rd_at(`NSCAP_OFF_RESV) ##0 ($past(rtype_reg) == 6'h00)) |=> rd_data_out == 8'h00)
    else $error("reservation byte not zero without reservations");

  a_resv_key_sel: assert property (
    (s_resv_live ##0 !$past(ver13_h)) |=> rd_data_out[`NSCAP_RESV_KEY_BIT] == $past(cfg_reg[`NSCAP_CFG_KEYNEW_BIT], 2))
    else $error("key semantics bit wrong");

  a_resv_key_ver: assert property (
    (s_resv_live ##0 $past(ver13_h)) |=> rd_data_out[`NSCAP_RESV_KEY_BIT])
    else $error("key semantics bit not forced by version");

  a_resv_reg_types: assert property (
    s_resv_live |=> rd_data_out[6:3] == $past(rtype_reg[5:2], 2))
    else $error("registrant type bits wrong");

  a_resv_excl_types: assert property (
    s_resv_live |=> rd_data_out[2:1] == $past(rtype_reg[1:0], 2))
    else $error("exclusive type bits wrong");

  a_resv_ptpl: assert property (
    s_resv_live |=> rd_data_out[0] == $past(cfg_reg[`NSCAP_CFG_PTPL_BIT], 2))
    else $error("persistence bit wrong");

  a_prog_unsup_zero: assert property (
    (s_rd_at(`NSCAP_OFF_PROG) ##0 !cfg_reg[`NSCAP_CFG_PROG_BIT]) |=> rd_data_out == 8'h00)
    else $error("progress byte not zero when unsupported");

  a_prog_pct_read: assert property (
    (s_rd_at(`NSCAP_OFF_PROG) ##0 cfg_reg[`NSCAP_CFG_PROG_BIT] ##0 fmt.busy)
      |=> (rd_data_out[7] && (rd_data_out[6:0] != 7'h00) && (rd_data_out[6:0] == $past(fmt.remaining))))
    else $error("progress byte does not show remaining share");

  a_fmt_start_full: assert property (
    s_fmt_start |=> fmt.busy && (fmt.remaining == `NSCAP_FMT_FULL_PCT))
    else $error("format did not start at full share");

  a_prog_zero_idle: assert property (
    (fmt.remaining == 7'h00) |-> !fmt.busy)
    else $error("zero share while format pending");

  a_fmt_commit: assert property (
    $fell(fmt.busy) |-> (fmt.remaining == 7'h00) && ($past(fmt.remaining) == 7'h01))
    else $error("format ended with share left");

  a_fmt_sel_read: assert property (
    s_rd_at(`NSCAP_OFF_FMT_SEL) |=> (rd_data_out[7:4] == 4'h0) && (rd_data_out[3:0] == $past(fmt.cur_fmt)))
    else $error("format select byte wrong");

  a_fmt_sel_stable: assert property (
    fmt.busy && $past(fmt.busy) |-> $stable(fmt.cur_fmt) && $stable(fmt.cur_prot))
    else $error("format changed mid operation");

  a_pct_monotone: assert property (
    (fmt.busy && $past(fmt.busy)) |-> fmt.remaining <= $past(fmt.remaining))
    else $error("remaining share rose");

  a_pct_step: assert property (
    (fmt.busy && $changed(fmt.remaining) && $past(fmt.busy)) |-> fmt.remaining == $past(fmt.remaining) - 7'h01)
    else $error("remaining share skipped");

  a_prot_always_legal: assert property (
    fmt.cur_prot <= `NSCAP_PROT_MAX)
    else $error("current protection code reserved");

  a_prot_cmd_taken: assert property (
    (cmd_wr && !fmt.busy && (wr_data_in[`NSCAP_CMD_PROT_LSB +: 3] <= `NSCAP_PROT_MAX)) |=> fmt.busy && !reject_reg)
    else $error("legal format command not taken");

  a_status_read: assert property (
    s_rd_at(`NSCAP_OFF_STATUS) |=> rd_data_out == {6'h00, $past(reject_reg), $past(fmt.busy)})
    else $error("status byte wrong");

  a_busy_cmd_refused: assert property (
    (cmd_wr && fmt.busy) |=> reject_reg && (fmt.remaining <= $past(fmt.remaining)))
    else $error("format restarted while running");

  a_cfg_read: assert property (
    s_rd_at(`NSCAP_OFF_CFG) |=> rd_data_out == {4'h0, $past(cfg_reg)})
    else $error("setting byte readback wrong");

  a_share_set_read: assert property (
    (s_rd_at(`NSCAP_OFF_SHARE) ##0 cfg_reg[`NSCAP_CFG_SHARED_BIT]) |=> rd_data_out == 8'h01)
    else $error("shared namespace not reported");

  a_share_clear_read: assert property (
    (s_rd_at(`NSCAP_OFF_SHARE) ##0 !cfg_reg[`NSCAP_CFG_SHARED_BIT]) |=> rd_data_out == 8'h00)
    else $error("private namespace not reported");

  a_resv_enc_zero: assert property (
    (rtype_reg == 6'h00) |=> resv_byte == 8'h00)
    else $error("encoder not zero without reservations");

  a_resv_enc_key: assert property (
    ((rtype_reg != 6'h00) && !ver13_h) |=> resv_byte[`NSCAP_RESV_KEY_BIT] == $past(cfg_reg[`NSCAP_CFG_KEYNEW_BIT]))
    else $error("encoder key bit wrong");

  a_resv_enc_ver: assert property (
    ((rtype_reg != 6'h00) && ver13_h) |=> resv_byte[`NSCAP_RESV_KEY_BIT])
    else $error("encoder key bit not forced");

  a_resv_enc_types: assert property (
    (rtype_reg != 6'h00) |=> resv_byte[6:3] == $past(rtype_reg[5:2]))
    else $error("encoder registrant bits wrong");

  a_resv_enc_excl: assert property (
    (rtype_reg != 6'h00) |=> resv_byte[2:1] == $past(rtype_reg[1:0]))
    else $error("encoder exclusive bits wrong");

  a_resv_enc_ptpl: assert property (
    (rtype_reg != 6'h00) |=> resv_byte[0] == $past(cfg_reg[`NSCAP_CFG_PTPL_BIT]))
    else $error("encoder persistence bit wrong");

  a_prog_sup_flag: assert property (
    (s_rd_at(`NSCAP_OFF_PROG) ##0 cfg_reg[`NSCAP_CFG_PROG_BIT]) |=> rd_data_out[`NSCAP_PROG_SUP_BIT])
    else $error("progress support bit missing");

  a_pct_in_range: assert property (
    fmt.remaining <= `NSCAP_FMT_FULL_PCT)
    else $error("remaining share above full");

  a_busy_pct_live: assert property (
    fmt.busy |-> fmt.remaining != 7'h00)
    else $error("running format shows zero share");

  a_prog_idle_read: assert property (
    (s_rd_at(`NSCAP_OFF_PROG) ##0 cfg_reg[`NSCAP_CFG_PROG_BIT] ##0 !fmt.busy) |=> rd_data_out == 8'h80)
    else $error("idle progress byte wrong");

  a_idle_pct_zero: assert property (
    !fmt.busy |-> fmt.remaining == 7'h00)
    else $error("idle engine shows share left");

  a_commit_target: assert property (
    $fell(fmt.busy) |-> (fmt.cur_fmt == chk_fmt_reg) && (fmt.cur_prot == chk_prot_reg))
    else $error("format end did not commit target");

  a_fmt_hold_idle: assert property (
    (!fmt.busy && !$past(fmt.busy)) |-> $stable(fmt.cur_fmt) && $stable(fmt.cur_prot))
    else $error("format changed while idle");

  a_prot_read_val: assert property (
    s_rd_at(`NSCAP_OFF_PROT) |=> rd_data_out[2:0] == $past(fmt.cur_prot))
    else $error("protection byte wrong");

  a_pct_last_step: assert property (
    s_fmt_last |=> fmt.remaining <= 7'h01)
    else $error("last step share rose");

  a_busy_out_lag: assert property (
    fmt_busy_out == $past(fmt.busy))
    else $error("busy output not one cycle behind");

  a_rtype_read: assert property (
    s_rd_at(`NSCAP_OFF_RTYPE) |=> rd_data_out == {1'b0, $past(rtype_reg), 1'b0})
    else $error("type byte readback wrong");

  a_ver_maj_read: assert property (
    s_rd_at(`NSCAP_OFF_VER_MAJ) |=> rd_data_out == $past(ver_maj_reg))
    else $error("major version readback wrong");

  a_ver_min_read: assert property (
    s_rd_at(`NSCAP_OFF_VER_MIN) |=> rd_data_out == $past(ver_min_reg))
    else $error("minor version readback wrong");
endmodule // nscap_top

// ===== verif/nscap_host_model.sv
// host-side bus master model driving the register port
`timescale 1ns/1ps
module nscap_host_model
  import nscap_pkg::*;
(
  input  wire logic        mclk_in,
  output nscap_byte_t      addr_out,
  output nscap_byte_t      wr_data_out,
  output logic             wr_out,
  output logic             rd_out,
  input  wire nscap_byte_t rd_data_in
);
  initial begin
    addr_out    = 8'h00;
    wr_data_out = 8'h00;
    wr_out      = 1'b0;
    rd_out      = 1'b0;
  end

  // one-cycle write; released lines show the inverse of the last value
  task automatic wr(input nscap_byte_t a, input nscap_byte_t d);
    @(posedge mclk_in);
    addr_out    <= a;
    wr_data_out <= d;
    wr_out      <= 1'b1;
    @(posedge mclk_in);
    wr_out      <= 1'b0;
    addr_out    <= ~a;
    wr_data_out <= ~d;
  endtask

  // one-cycle read; data taken in the cycle after the strobe
  task automatic rd(input nscap_byte_t a, output nscap_byte_t d);
    @(posedge mclk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge mclk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    #1 d = rd_data_in;
  endtask
endmodule // nscap_host_model

// ===== verif/nscap_top_bench.sv
// self-checking bench for the namespace capability bank
`timescale 1ns/1ps
module nscap_top_bench;
  import nscap_pkg::*;
  localparam int STEP = 2;
  logic        mclk_in;
  logic        rst_in;
  logic        wr;
  logic        rd;
  logic        busy;
  nscap_byte_t addr;
  nscap_byte_t wdat;
  nscap_byte_t rdat;
  nscap_byte_t v;
  nscap_byte_t last;
  int          mismatches;
  int          checked;
  int          cycles;

  initial mclk_in = 1'b0;
  always #12.5 mclk_in = ~mclk_in;

  nscap_top #(.STEP_CYCLES(STEP)) nscap_top_inst (
    .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr), .wr_data_in(wdat),
    .wr_in(wr), .rd_in(rd), .rd_data_out(rdat), .fmt_busy_out(busy));

  nscap_host_model nscap_host_model_inst (
    .mclk_in(mclk_in), .addr_out(addr), .wr_data_out(wdat), .wr_out(wr),
    .rd_out(rd), .rd_data_in(rdat));

  task automatic end_of_test();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input nscap_byte_t e, input nscap_byte_t g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic w(input nscap_byte_t a, input nscap_byte_t d);
    nscap_host_model_inst.wr(a, d);
  endtask

  task automatic rchk(input nscap_byte_t a, input nscap_byte_t e);
    nscap_byte_t d;
    nscap_host_model_inst.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask

  // hang guard
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    mismatches = 0;
    checked    = 0;
    cycles     = 0;
    rst_in     = 1'b1;
    repeat (16) @(posedge mclk_in);
    rst_in <= 1'b0;
    // reset state
    rchk(8'h1E, 8'h00);
    rchk(8'h1F, 8'h00);
    rchk(8'h20, 8'h00);
    rchk(8'h1A, 8'h00);
    rchk(8'h1D, 8'h00);
    rchk(8'h00, 8'h00);
    // sharing byte
    w(8'h40, 8'h01);
    rchk(8'h1E, 8'h01);
    w(8'h1E, 8'hFF);
    rchk(8'h1E, 8'h01);
    w(8'h40, 8'h00);
    rchk(8'h1E, 8'h00);
    // reservation types one by one at version 1.4, then key and persistence bits at 1.2 to 2.0
    for (int i = 1; i < 7; i++) begin
      w(8'h41, 8'h01 << i);
      rchk(8'h1F, 8'h80 | (8'h01 << i));
    end
    w(8'h43, 8'h02);
    w(8'h41, 8'h02);
    rchk(8'h1F, 8'h02);
    w(8'h40, 8'h08);
    rchk(8'h1F, 8'h82);
    w(8'h40, 8'h00);
    w(8'h43, 8'h03);
    rchk(8'h1F, 8'h82);
    w(8'h42, 8'h02);
    w(8'h43, 8'h00);
    rchk(8'h1F, 8'h82);
    w(8'h40, 8'h04);
    rchk(8'h1F, 8'h83);
    w(8'h41, 8'h00);
    rchk(8'h1F, 8'h00);
    // progress byte
    rchk(8'h20, 8'h00);
    w(8'h40, 8'h02);
    rchk(8'h20, 8'h80);
    w(8'h44, 8'h45);
    rchk(8'h1D, 8'h00);
    rchk(8'h45, 8'h02);
    chk("busy", 8'h00, {7'h00, busy});
    // one format per protection code
    for (int p = 0; p < 4; p++) begin
      w(8'h44, {1'b0, p[2:0], 4'h8 + p[3:0]});
      rchk(8'h20, 8'hE4);
      w(8'h44, 8'h31);
      rchk(8'h45, 8'h03);
      chk("busy", 8'h01, {7'h00, busy});
      last = 8'hE4;
      for (int n = 0; n < 400 && last !== 8'h80; n++) begin
        nscap_host_model_inst.rd(8'h20, v);
        if (v[6:0] > last[6:0] || v[7] !== 1'b1) chk("progress", last, v);
        last = v;
      end
      chk("progress end", 8'h80, last);
      rchk(8'h1A, 8'h08 + {4'h0, p[3:0]});
      rchk(8'h1D, {5'h00, p[2:0]});
      rchk(8'h45, 8'h02);
      chk("busy", 8'h00, {7'h00, busy});
    end
    w(8'h40, 8'h00);
    rchk(8'h20, 8'h00);
    end_of_test();
  end
endmodule // nscap_top_bench
